// file: rtl/trap_pkg.sv
// Constants for the trap vector and priority status block
package trap_pkg;
   // APB register byte offsets
   localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h00;
   localparam logic [7:0] ADDR_CORE_CTRL    = 8'h04;
   localparam logic [7:0] ADDR_INT_CTRL_ONE = 8'h08;
   localparam logic [7:0] ADDR_ALT_BASE     = 8'h0C;
   localparam logic [7:0] ADDR_TRAP_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_TRAP_MASK    = 8'h14;
   localparam logic [7:0] ADDR_TRAP_INFO    = 8'h18;
   // Status register field positions
   localparam int SR_DC_BIT  = 8;
   localparam int SR_IPL_LSB = 5;
   localparam int SR_RA_BIT  = 4;
   localparam logic [15:0] SR_RESET      = 16'h0000;
   localparam logic [15:0] SR_WRITE_MASK = 16'h01EF;
   // Core control: high priority bit position
   localparam int CC_IPL_HI_BIT = 3;
   localparam int IC_NEST_DIS_BIT = 15;
   // Vector tables
   localparam logic [23:0] VEC_BASE       = 24'h000004;
   localparam logic [23:0] VEC_LAST       = 24'h000012;
   localparam logic [23:0] ALT_BASE_RESET = 24'h000000;
   localparam int NUM_TRAPS = 8;
   localparam logic [7:0] TRAP_VALID = 8'h5F;
   // Trap slot numbers
   localparam logic [2:0] TRAP_OSC_FAIL = 3'h0;
   localparam logic [2:0] TRAP_ADDR_ERR = 3'h1;
   // Data window page that aliases base memory
   localparam logic [7:0] EDS_PAGE_ZERO = 8'h00;
   localparam logic [3:0] TRAP_LEVEL = 4'hF;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_DONE  = 3'b100
   } trap_state_e;
endpackage

// file: rtl/trap_priority_enc.sv
// Lowest-numbered pending trap selector
`timescale 1ns/1ps
`default_nettype none
module trap_priority_enc (
   input  wire logic [7:0] i_req,
   output logic            o_any,
   output logic [2:0]      o_slot
);
   always_comb begin
      o_any  = 1'b0;
      o_slot = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (i_req[k]) begin
            o_any  = 1'b1;
            o_slot = 3'(k);
         end
      end
   end
endmodule // trap_priority_enc
`default_nettype wire

// file: rtl/trap_vector_addr.sv
// Vector address from slot and table selection
`timescale 1ns/1ps
`default_nettype none
module trap_vector_addr (
   input  wire logic [2:0]  i_slot,
   input  wire logic        i_use_alt,
   input  wire logic [23:0] i_alt_base,
   output logic [23:0]      o_addr
);
   logic [23:0] base;
   always_comb begin
      base   = i_use_alt ? i_alt_base : 24'h000000;
      // Two-byte word slots from the table start
      o_addr = base + trap_pkg::VEC_BASE + {20'h00000, i_slot, 1'b0};
   end
endmodule // trap_vector_addr
`default_nettype wire

// file: rtl/trap_vector_priority_status.sv
// Trap vectoring, priority level and status register with APB access
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module trap_vector_priority_status (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_b,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Core side
   input  wire logic [7:0]  i_trap_req,
   input  wire logic        i_eds_access,
   input  wire logic [7:0]  i_eds_page,
   input  wire logic        i_use_alt_table,
   input  wire logic        i_trap_ack,
   input  wire logic        i_flags_we,
   input  wire logic [4:0]  i_flags,
   input  wire logic        i_repeat_active,
   input  wire logic        i_user_irq_req,
   input  wire logic [3:0]  i_user_irq_level,
   output logic             o_trap_take,
   output logic [23:0]      o_vector_addr,
   output logic [2:0]       o_trap_slot,
   output logic [3:0]       o_cpu_level,
   output logic             o_user_irq_take,
   output logic             o_irq
);
   trap_pkg::trap_state_e state;
   logic [15:0] cpu_status_flags;
   logic [15:0] core_control_reg;
   logic [15:0] interrupt_control_one;
   logic [23:0] alt_table_base;
   logic [7:0]  trap_status;
   logic [7:0]  trap_mask;
   logic [7:0]  pending;
   logic [2:0]  cur_slot;
   logic        cur_alt;
   logic [2:0]  saved_ipl;
   logic        in_trap;
   logic [7:0]  trap_events;
   logic        enc_any;
   logic [2:0]  enc_slot;
   logic [23:0] vec_addr;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [2:0]  cpu_priority_field;
   logic        priority_high_bit;
   logic        nesting_disable;
   logic [3:0]  level;
   logic [31:0] next_rdata;
   logic        setup_phase;
   logic        accept;
   logic [7:0]  take_clear;
   logic        user_ok;

   assign cpu_priority_field = cpu_status_flags[trap_pkg::SR_IPL_LSB +: 3];
   assign priority_high_bit  = core_control_reg[trap_pkg::CC_IPL_HI_BIT];
   assign nesting_disable    = interrupt_control_one[trap_pkg::IC_NEST_DIS_BIT];
   // Trap in service pins the level to the top
   assign level = in_trap ? trap_pkg::TRAP_LEVEL
                          : {priority_high_bit, cpu_priority_field};

   // Page zero aliases base memory, so it is refused
   always_comb begin
      trap_events = i_trap_req & trap_pkg::TRAP_VALID;
      if (i_eds_access && i_eds_page == trap_pkg::EDS_PAGE_ZERO) begin
         trap_events[trap_pkg::TRAP_ADDR_ERR] = 1'b1;
      end
   end

   trap_priority_enc u_enc (
      .i_req  (pending),
      .o_any  (enc_any),
      .o_slot (enc_slot)
   );

   trap_vector_addr u_vec (
      .i_slot     (cur_slot),
      .i_use_alt  (cur_alt),
      .i_alt_base (alt_table_base),
      .o_addr     (vec_addr)
   );

   assign setup_phase = i_psel && !i_penable;
   assign wr_en       = i_psel && i_penable && i_pwrite;
   assign rd_en       = setup_phase && !i_pwrite;

   // Unmapped offsets answer with an error and change nothing
   always_comb begin
      addr_ok = 1'b0;
      case (i_paddr)
         trap_pkg::ADDR_STATUS_FLAGS,
         trap_pkg::ADDR_CORE_CTRL,
         trap_pkg::ADDR_INT_CTRL_ONE,
         trap_pkg::ADDR_ALT_BASE,
         trap_pkg::ADDR_TRAP_STATUS,
         trap_pkg::ADDR_TRAP_MASK,
         trap_pkg::ADDR_TRAP_INFO: begin
            addr_ok = 1'b1;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // The taken slot leaves the pending set as it is accepted
   assign accept     = (state == trap_pkg::ST_IDLE) && enc_any;
   assign take_clear = accept ? (8'h01 << enc_slot) : 8'h00;

   // Pending traps: set wins over the taking clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         pending <= 8'h00;
      end else begin
         pending <= (pending & ~take_clear) | trap_events;
      end
   end

   // Trap sequencer
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         state         <= trap_pkg::ST_IDLE;
         cur_slot      <= 3'h0;
         cur_alt       <= 1'b0;
         in_trap       <= 1'b0;
         o_trap_take   <= 1'b0;
         o_vector_addr <= 24'h000000;
         o_trap_slot   <= 3'h0;
      end else begin
         o_trap_take <= 1'b0;
         case (state)
            trap_pkg::ST_IDLE: begin
               if (enc_any) begin
                  cur_slot <= enc_slot;
                  cur_alt  <= i_use_alt_table;
                  in_trap  <= 1'b1;
                  state    <= trap_pkg::ST_FETCH;
               end
            end
            trap_pkg::ST_FETCH: begin
               o_vector_addr <= vec_addr;
               o_trap_slot   <= cur_slot;
               o_trap_take   <= 1'b1;
               state         <= trap_pkg::ST_DONE;
            end
            trap_pkg::ST_DONE: begin
               // Level stays raised until the handler returns
               if (i_trap_ack) begin
                  in_trap <= 1'b0;
                  state   <= trap_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= trap_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Status register: software and core updates
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         cpu_status_flags <= trap_pkg::SR_RESET;
         saved_ipl        <= 3'h0;
      end else begin
         cpu_status_flags[trap_pkg::SR_RA_BIT] <= i_repeat_active;
         if (i_flags_we) begin
            cpu_status_flags[trap_pkg::SR_DC_BIT] <= i_flags[4];
            cpu_status_flags[3:0]                 <= i_flags[3:0];
         end
         if (wr_en && i_paddr == trap_pkg::ADDR_STATUS_FLAGS) begin
            if (i_pstrb[0]) begin
               cpu_status_flags[3:0] <= i_pwdata[3:0];
               if (!nesting_disable) begin
                  cpu_status_flags[7:5] <= i_pwdata[7:5];
               end
            end
            if (i_pstrb[1]) begin
               cpu_status_flags[trap_pkg::SR_DC_BIT] <= i_pwdata[8];
            end
         end
         if (accept) begin
            saved_ipl <= cpu_priority_field;
         end
      end
   end

   // Control registers
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         core_control_reg      <= 16'h0000;
         interrupt_control_one <= 16'h0000;
         alt_table_base        <= trap_pkg::ALT_BASE_RESET;
         trap_mask             <= 8'h00;
      end else if (wr_en) begin
         case (i_paddr)
            trap_pkg::ADDR_CORE_CTRL: begin
               if (i_pstrb[0]) core_control_reg[7:0] <= i_pwdata[7:0];
               if (i_pstrb[1]) core_control_reg[15:8] <= i_pwdata[15:8];
            end
            trap_pkg::ADDR_INT_CTRL_ONE: begin
               if (i_pstrb[0]) interrupt_control_one[7:0] <= i_pwdata[7:0];
               if (i_pstrb[1]) interrupt_control_one[15:8] <= i_pwdata[15:8];
            end
            trap_pkg::ADDR_ALT_BASE: begin
               if (i_pstrb[0]) alt_table_base[7:0] <= i_pwdata[7:0];
               if (i_pstrb[1]) alt_table_base[15:8] <= i_pwdata[15:8];
               if (i_pstrb[2]) alt_table_base[23:16] <= i_pwdata[23:16];
            end
            trap_pkg::ADDR_TRAP_MASK: begin
               if (i_pstrb[0]) trap_mask <= i_pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky trap status, write one to clear, new event wins
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         trap_status <= 8'h00;
      end else begin
         if (wr_en && i_paddr == trap_pkg::ADDR_TRAP_STATUS && i_pstrb[0]) begin
            trap_status <= (trap_status & ~i_pwdata[7:0]) | trap_events;
         end else begin
            trap_status <= trap_status | trap_events;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(trap_status & trap_mask);
      end
   end

   // The high bit and a trap in service both shut out user requests
   assign user_ok = i_user_irq_req && !priority_high_bit && !in_trap &&
                    (i_user_irq_level > level);

   // Level and user interrupt gating
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_cpu_level     <= 4'h0;
         o_user_irq_take <= 1'b0;
      end else begin
         o_cpu_level     <= level;
         o_user_irq_take <= user_ok;
      end
   end

   // Read data latched in setup, returned with no wait state
   always_comb begin
      next_rdata = 32'h00000000;
      case (i_paddr)
         trap_pkg::ADDR_STATUS_FLAGS: next_rdata = {16'h0000, cpu_status_flags};
         trap_pkg::ADDR_CORE_CTRL:    next_rdata = {16'h0000, core_control_reg};
         trap_pkg::ADDR_INT_CTRL_ONE: next_rdata = {16'h0000, interrupt_control_one};
         trap_pkg::ADDR_ALT_BASE:     next_rdata = {8'h00, alt_table_base};
         trap_pkg::ADDR_TRAP_STATUS:  next_rdata = {24'h000000, trap_status};
         trap_pkg::ADDR_TRAP_MASK:    next_rdata = {24'h000000, trap_mask};
         trap_pkg::ADDR_TRAP_INFO:    next_rdata = {20'h00000, in_trap, saved_ipl,
                                                    level, 1'b0, cur_slot};
         default:                     next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_prdata  <= 32'h00000000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         if (rd_en) begin
            o_prdata <= next_rdata;
         end
         o_pready  <= setup_phase;
         o_pslverr <= setup_phase && !addr_ok;
      end
   end
endmodule // trap_vector_priority_status
`default_nettype wire

// file: testbench/core_exec_model.sv
// Core execution side: returns from each trap handler after a delay
`timescale 1ns/1ps
`default_nettype none
module core_exec_model (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   input  wire logic i_take,
   input  wire logic i_slow,
   output logic      o_ack
);
   logic [3:0] cnt;
   logic       busy;
   // Slow handlers keep later traps pending for longer
   always_ff @(posedge i_sys_clk) begin
      o_ack <= 1'b0;
      if (!i_rst_b) begin
         busy <= 1'b0;
         cnt  <= 4'h0;
      end else if (i_take) begin
         busy <= 1'b1;
         cnt  <= i_slow ? 4'hA : 4'h0;
      end else if (busy) begin
         if (cnt == 4'h0) begin
            busy  <= 1'b0;
            o_ack <= 1'b1;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // core_exec_model
`default_nettype wire

// file: testbench/trap_vector_priority_status_assertions.sv
// Port checks for the trap vector and priority status block
`timescale 1ns/1ps
`default_nettype none
module tvps_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_b,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_use_alt_table,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_trap_take,
   input wire logic [23:0] o_vector_addr,
   input wire logic [2:0]  o_trap_slot,
   input wire logic [3:0]  o_cpu_level,
   input wire logic        o_user_irq_take
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   AST_SETUP_READY: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
   AST_READY_ACCESS: assert property (o_pready |-> i_psel && i_penable ##1 !o_pready)
      else $error("ready outside one access cycle");
   AST_TAKE_PULSE: assert property (o_trap_take |=> !o_trap_take)
      else $error("trap take longer than a cycle");
   AST_TAKE_LEVEL: assert property (
      o_trap_take |-> o_cpu_level == trap_pkg::TRAP_LEVEL)
      else $error("level not raised on trap");
   AST_SLOT_LEGAL: assert property (
      o_trap_take |-> o_trap_slot != 3'h5 && o_trap_slot != 3'h7)
      else $error("reserved slot taken");
   AST_VEC_PRIMARY: assert property (o_trap_take && !$past(i_use_alt_table)
      && !$past(i_use_alt_table, 2) |-> o_vector_addr == 24'h4 + {20'h0, o_trap_slot, 1'b0})
      else $error("primary vector address wrong");
   AST_VEC_HOLD: assert property (o_trap_take |=> $stable(o_vector_addr) [*2])
      else $error("vector address not held");
   AST_USER_BLOCK: assert property (o_user_irq_take |-> !o_cpu_level[3])
      else $error("user interrupt taken at high level");
   COV_ALT: cover property (o_trap_take && i_use_alt_table);
   COV_USER: cover property (o_user_irq_take);
   COV_ERR: cover property (o_pready && o_pslverr);
endmodule // tvps_checker
bind trap_vector_priority_status tvps_checker u_tvps_checker (.i_sys_clk, .i_rst_b, .i_psel,
   .i_penable, .i_use_alt_table, .o_pready, .o_pslverr, .o_trap_take, .o_vector_addr,
   .o_trap_slot, .o_cpu_level, .o_user_irq_take);
`default_nettype wire

// file: testbench/trap_vector_priority_status_tb.sv
// Self-checking bench for the trap vector and priority status block
`timescale 1ns/1ps
`default_nettype none
module trap_vector_priority_status_tb;
   logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, alt = 0, extended_data_window = 0;
   logic        fwe = 0, ra = 0, ureq = 0, slow = 0, ack, rdy, err, take, utake, irq;
   logic [7:0]  paddr = 0, treq = 0, page = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [4:0]  f, flags = 0;
   logic [3:0]  ulvl = 0, lvl;
   logic [23:0] vec;
   logic [2:0]  slot;
   logic [32:0] rq[$];
   logic [26:0] tq[$];
   int          miscompares = 0, n_tests = 0;
   always #5 clk = ~clk;
   trap_vector_priority_status u_trap_vector_priority_status (.i_sys_clk(clk), .i_rst_b(rst_b),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(err),
      .i_trap_req(treq), .i_eds_access(extended_data_window), .i_eds_page(page), .i_use_alt_table(alt),
      .i_trap_ack(ack), .i_flags_we(fwe), .i_flags(flags), .i_repeat_active(ra),
      .i_user_irq_req(ureq), .i_user_irq_level(ulvl), .o_trap_take(take),
      .o_vector_addr(vec), .o_trap_slot(slot), .o_cpu_level(lvl),
      .o_user_irq_take(utake), .o_irq(irq));
   core_exec_model u_core_exec_model (.i_sys_clk(clk), .i_rst_b(rst_b), .i_take(take),
      .i_slow(slow), .o_ack(ack));
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Request held until ready is sampled, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk) pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      psel <= 1'b0; pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic drain;
      for (int k = 0; k < 400 && (tq.size() != 0 || lvl === 4'hF); k++) @(posedge clk);
      // A wait that runs out is a failure, not a silent exit
      check("drain", 33'(tq.size()) | 33'(lvl === 4'hF), 33'h0);
   endtask
   always @(posedge clk) begin
      if (rdy === 1'b1 && psel && pen && !pwr)
         check("read", {err, prdata}, rq.pop_front());
      if (take === 1'b1) check("trap", {slot, vec}, tq.pop_front());
   end
   initial begin
      #200000;
      miscompares++;
      conclude;
   end
   initial begin
      void'($urandom(32'hE7A64A4F));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(trap_pkg::ADDR_STATUS_FLAGS, 33'h0);
      rd(trap_pkg::ADDR_CORE_CTRL, 33'h0);
      rd(8'h1C, 33'h1_0000_0000);
      apb(1'b1, trap_pkg::ADDR_STATUS_FLAGS, 32'hFFFF_FFFF);
      rd(trap_pkg::ADDR_STATUS_FLAGS, 33'h01EF);
      f = 5'($urandom);
      flags <= f; fwe <= 1'b1; ra <= 1'b1;
      @(posedge clk) fwe <= 1'b0;
      repeat (2) @(posedge clk);
      rd(trap_pkg::ADDR_STATUS_FLAGS, {24'h0, f[4], 3'h7, 1'b1, f[3:0]});
      apb(1'b1, trap_pkg::ADDR_INT_CTRL_ONE, 32'h8000);
      apb(1'b1, trap_pkg::ADDR_STATUS_FLAGS, 32'h0);
      rd(trap_pkg::ADDR_STATUS_FLAGS, {24'h0, f[4] & 1'b0, 3'h7, 1'b1, 4'h0});
      apb(1'b1, trap_pkg::ADDR_INT_CTRL_ONE, 32'h0);
      ra <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, trap_pkg::ADDR_CORE_CTRL, {28'h0, i[3], 3'h0});
         apb(1'b1, trap_pkg::ADDR_STATUS_FLAGS, {24'h0, i[2:0], 5'h0});
         ulvl <= 4'($urandom); ureq <= 1'b1;
         repeat (3) @(posedge clk);
         check("level", lvl, i[3:0]);
         check("user", utake, !i[3] && ulvl > i[3:0]);
      end
      ureq <= 1'b0;
      // Idle level back to zero so a drain can tell a trap from idle
      apb(1'b1, trap_pkg::ADDR_CORE_CTRL, 32'h0);
      apb(1'b1, trap_pkg::ADDR_STATUS_FLAGS, 32'h0);
      apb(1'b1, trap_pkg::ADDR_ALT_BASE, 32'h00C000);
      // All slots at once: lowest first, reserved ones never taken
      for (int a = 0; a < 2; a++) begin
         alt <= a[0]; slow <= a[0];
         for (int s = 0; s < 8; s++)
            if (s != 5 && s != 7)
               tq.push_back({s[2:0], (a[0] ? 24'hC000 : 24'h0) + 24'(4 + 2 * s)});
         @(posedge clk) treq <= 8'hFF;
         @(posedge clk) treq <= 8'h00;
         drain;
      end
      rd(trap_pkg::ADDR_TRAP_STATUS, 33'h5F);
      apb(1'b1, trap_pkg::ADDR_TRAP_STATUS, 32'hFF);
      page <= 8'($urandom) | 8'h01; extended_data_window <= 1'b1;
      @(posedge clk) extended_data_window <= 1'b0;
      drain;
      rd(trap_pkg::ADDR_TRAP_STATUS, 33'h0);
      tq.push_back({3'h1, 24'h00C006});
      page <= 8'h00; extended_data_window <= 1'b1;
      @(posedge clk) extended_data_window <= 1'b0;
      drain;
      rd(trap_pkg::ADDR_TRAP_STATUS, 33'h02);
      apb(1'b1, trap_pkg::ADDR_TRAP_MASK, 32'h02);
      @(posedge clk) check("irq", irq, 33'h1);
      apb(1'b1, trap_pkg::ADDR_TRAP_MASK, 32'h01);
      @(posedge clk) check("irq", irq, 33'h0);
      apb(1'b1, trap_pkg::ADDR_TRAP_MASK, 32'h02);
      apb(1'b1, trap_pkg::ADDR_TRAP_STATUS, 32'h02);
      @(posedge clk) check("irq", irq, 33'h0);
      check("pending", 33'(tq.size() + rq.size()), 33'h0);
      conclude;
   end
endmodule // trap_vector_priority_status_tb
`default_nettype wire
